//--- core/csm_pkg.sv
// constants, carriers and register map of the configurable signed multiplier
package csm_pkg;

  // datapath geometry
  localparam int unsigned CSM_WIDE_W   = 18;
  localparam int unsigned CSM_NARROW_W = 9;
  localparam int unsigned CSM_SECTIONS = 2;
  localparam int unsigned CSM_PROD_W   = 2 * CSM_WIDE_W;
  localparam int unsigned CSM_LANE_PW  = 2 * CSM_NARROW_W;

  // bus geometry
  localparam int unsigned CSM_ADDR_W = 12;
  localparam int unsigned CSM_DATA_W = 32;

  // register byte offsets
  localparam logic [11:0] CSM_OFS_CTRL    = 12'h000;
  localparam logic [11:0] CSM_OFS_STATUS  = 12'h004;
  localparam logic [11:0] CSM_OFS_PROD_LO = 12'h008;
  localparam logic [11:0] CSM_OFS_PROD_HI = 12'h00C;
  localparam logic [11:0] CSM_OFS_COUNT   = 12'h010;

  // control field positions
  localparam int unsigned CSM_CTRL_NARROW   = 0;
  localparam int unsigned CSM_CTRL_REG_A    = 1;
  localparam int unsigned CSM_CTRL_REG_B    = 2;
  localparam int unsigned CSM_CTRL_REG_SIGN = 3;
  localparam int unsigned CSM_CTRL_REG_OUT  = 4;
  localparam int unsigned CSM_CTRL_SIGN_EN  = 5;
  localparam int unsigned CSM_CTRL_W        = 6;

  // status field positions
  localparam int unsigned CSM_STAT_SIGNED = 0;
  localparam int unsigned CSM_STAT_NARROW = 1;
  localparam int unsigned CSM_STAT_SIGN_A = 2;
  localparam int unsigned CSM_STAT_SIGN_B = 3;

  // values after reset
  localparam logic [5:0]  CSM_CTRL_RST  = 6'h00;
  localparam logic [31:0] CSM_COUNT_RST = 32'h00000000;
  localparam logic [31:0] CSM_RDATA_RST = 32'h00000000;

  // field order matches the control bit positions above
  typedef struct packed {
    logic sign_en;
    logic reg_out;
    logic reg_sign;
    logic reg_b;
    logic reg_a;
    logic narrow;
  } csm_cfg_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } csm_apb_req_t;

  typedef struct packed {
    logic [17:0] a;
    logic [17:0] b;
    logic        sign_a;
    logic        sign_b;
  } csm_opnd_t;

  typedef struct packed {
    logic [35:0] product;
    logic        is_signed;
  } csm_res_t;

  typedef struct packed {
    csm_cfg_t    cfg;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [31:0] count;
  } csm_regs_t;

endpackage : csm_pkg

//--- core/csm_mul.sv
// one full-precision multiplier lane with per-operand sign control
`timescale 1ns/100ps
`default_nettype none
module csm_mul
  import csm_pkg::*;
#(
  parameter int unsigned W = 18
) (
  // operands
  input  wire logic [W-1:0]   a,
  input  wire logic [W-1:0]   b,
  input  wire logic           sign_a,
  input  wire logic           sign_b,
  // result
  output logic      [2*W-1:0] p
);

  logic signed [W:0]     a_ext;
  logic signed [W:0]     b_ext;
  logic signed [2*W+1:0] full;

  // one extra bit per operand makes unsigned and signed share one multiply
  always_comb begin
    a_ext = $signed({sign_a & a[W-1], a});
    b_ext = $signed({sign_b & b[W-1], b});
    full  = a_ext * b_ext;
    // any mix of signs fits in 2W bits, so nothing is lost here
    p     = full[2*W-1:0];
  end

endmodule : csm_mul
`default_nettype wire

//--- core/csm_pipe.sv
// one section register of the slice: shared enable and clear
`timescale 1ns/100ps
`default_nettype none
module csm_pipe
  import csm_pkg::*;
#(
  parameter int unsigned W = 9
) (
  // clock and shared controls
  input  wire logic         clk,
  input  wire logic         clr,
  input  wire logic         ce,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] data;
  } csm_pipe_st_t;

  csm_pipe_st_t st_ff;
  csm_pipe_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (ce) begin
      nxt_st.data = d;
    end
  end

  always_ff @(posedge clk or posedge clr) begin
    if (clr) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.data;

endmodule : csm_pipe
`default_nettype wire

//--- core/csm_top.sv
// configurable signed multiplier slice with APB configuration
`timescale 1ns/100ps
`default_nettype none
module csm_top
  import csm_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // slice controls from fabric
  input  wire logic        CLK_EN,
  input  wire logic        ACLR,
  // operands from fabric
  input  wire logic [17:0] DATA_A,
  input  wire logic [17:0] DATA_B,
  input  wire logic        SIGN_A,
  input  wire logic        SIGN_B,
  // result to fabric
  output logic      [35:0] PRODUCT,
  output logic             RESULT_SIGNED
);

  // bus side state
  csm_regs_t    regs_ff;
  csm_regs_t    nxt_regs;
  csm_apb_req_t req;

  // slice datapath signals
  logic      slice_clr;
  csm_opnd_t opnd_in;
  csm_opnd_t opnd_q;
  csm_opnd_t opnd_use;
  logic      [1:0]  sign_in;
  logic      [1:0]  sign_q;
  logic      [35:0] wide_p;
  logic      [35:0] narrow_p;
  csm_res_t  res_comb;
  csm_res_t  res_q;
  csm_res_t  res_out;
  logic      [35:0] prod_q;
  logic      signed_q;

  assign req = '{psel:    PSEL,
                 penable: PENABLE,
                 pwrite:  PWRITE,
                 paddr:   PADDR,
                 pwdata:  PWDATA};

  // one clear for every slice register; RST also empties the pipeline
  // so that a fresh configuration never sees stale products
  assign slice_clr = RST | ACLR;

  // sign controls
  // sign_en low stands for controls that are not connected
  assign sign_in = regs_ff.cfg.sign_en ? {SIGN_A, SIGN_B} : 2'h0;

  assign opnd_in = '{a:      DATA_A,
                     b:      DATA_B,
                     sign_a: sign_in[1],
                     sign_b: sign_in[0]};

  // the sign pair has a register of its own so it lines up with
  // registered operands; both may change every cycle
  csm_pipe #(
    .W (2)
  ) u_sign_reg (
    .clk (CLK),
    .clr (slice_clr),
    .ce  (CLK_EN),
    .d   (sign_in),
    .q   (sign_q)
  );

  // operand input registers, 9-bit sections
  genvar gs;
  generate
    for (gs = 0; gs < CSM_SECTIONS; gs++) begin : g_in_sec
      csm_pipe #(
        .W (CSM_NARROW_W)
      ) u_a_reg (
        .clk (CLK),
        .clr (slice_clr),
        .ce  (CLK_EN),
        .d   (opnd_in.a[gs*CSM_NARROW_W +: CSM_NARROW_W]),
        .q   (opnd_q.a[gs*CSM_NARROW_W +: CSM_NARROW_W])
      );

      csm_pipe #(
        .W (CSM_NARROW_W)
      ) u_b_reg (
        .clk (CLK),
        .clr (slice_clr),
        .ce  (CLK_EN),
        .d   (opnd_in.b[gs*CSM_NARROW_W +: CSM_NARROW_W]),
        .q   (opnd_q.b[gs*CSM_NARROW_W +: CSM_NARROW_W])
      );
    end
  endgenerate

  assign opnd_q.sign_a = sign_q[1];
  assign opnd_q.sign_b = sign_q[0];

  // each operand picks registered or direct independently
  always_comb begin
    opnd_use.a      = regs_ff.cfg.reg_a ? opnd_q.a : opnd_in.a;
    opnd_use.b      = regs_ff.cfg.reg_b ? opnd_q.b : opnd_in.b;
    opnd_use.sign_a = regs_ff.cfg.reg_sign ? opnd_q.sign_a
                                           : opnd_in.sign_a;
    opnd_use.sign_b = regs_ff.cfg.reg_sign ? opnd_q.sign_b
                                           : opnd_in.sign_b;
  end

  // multiplier stage
  // wide lane: operands of 10 to 18 bits; narrower signed values must be
  // sign extended by the fabric to the full 18 bits
  csm_mul #(
    .W (CSM_WIDE_W)
  ) u_mul_wide (
    .a      (opnd_use.a),
    .b      (opnd_use.b),
    .sign_a (opnd_use.sign_a),
    .sign_b (opnd_use.sign_b),
    .p      (wide_p)
  );

  // two narrow lanes share the single sign pair, so both A halves and
  // both B halves are read the same way
  generate
    for (gs = 0; gs < CSM_SECTIONS; gs++) begin : g_lane
      csm_mul #(
        .W (CSM_NARROW_W)
      ) u_mul_narrow (
        .a      (opnd_use.a[gs*CSM_NARROW_W +: CSM_NARROW_W]),
        .b      (opnd_use.b[gs*CSM_NARROW_W +: CSM_NARROW_W]),
        .sign_a (opnd_use.sign_a),
        .sign_b (opnd_use.sign_b),
        .p      (narrow_p[gs*CSM_LANE_PW +: CSM_LANE_PW])
      );
    end
  endgenerate

  always_comb begin
    res_comb.product   = regs_ff.cfg.narrow ? narrow_p : wide_p;
    res_comb.is_signed = opnd_use.sign_a | opnd_use.sign_b;
  end

  // output registers, 18-bit sections
  generate
    for (gs = 0; gs < CSM_SECTIONS; gs++) begin : g_out_sec
      csm_pipe #(
        .W (CSM_LANE_PW)
      ) u_p_reg (
        .clk (CLK),
        .clr (slice_clr),
        .ce  (CLK_EN),
        .d   (res_comb.product[gs*CSM_LANE_PW +: CSM_LANE_PW]),
        .q   (prod_q[gs*CSM_LANE_PW +: CSM_LANE_PW])
      );
    end
  endgenerate

  csm_pipe #(
    .W (1)
  ) u_signed_reg (
    .clk (CLK),
    .clr (slice_clr),
    .ce  (CLK_EN),
    .d   (res_comb.is_signed),
    .q   (signed_q)
  );

  assign res_q.product   = prod_q;
  assign res_q.is_signed = signed_q;

  // with the output register off the product is combinational from the
  // operand path; that is the whole point of the bypass
  assign res_out       = regs_ff.cfg.reg_out ? res_q : res_comb;
  assign PRODUCT       = res_out.product;
  assign RESULT_SIGNED = res_out.is_signed;

  // apb register file
  logic        acc_phase;
  logic        acc_done;
  logic        hit;
  logic [31:0] rdata;
  logic [31:0] status;
  logic [11:0] word_addr;

  assign word_addr = {req.paddr[11:2], 2'h0};
  assign acc_phase = req.psel & req.penable;
  assign acc_done  = acc_phase & regs_ff.pready;

  always_comb begin
    status                  = 32'h00000000;
    status[CSM_STAT_SIGNED] = res_out.is_signed;
    status[CSM_STAT_NARROW] = regs_ff.cfg.narrow;
    status[CSM_STAT_SIGN_A] = opnd_use.sign_a;
    status[CSM_STAT_SIGN_B] = opnd_use.sign_b;
  end

  // read mux; an unmapped word reads zero and raises the error flag
  always_comb begin
    hit   = 1'b1;
    rdata = 32'h00000000;
    case (word_addr)
      CSM_OFS_CTRL: begin
        rdata[CSM_CTRL_W-1:0] = regs_ff.cfg;
      end
      CSM_OFS_STATUS: begin
        rdata = status;
      end
      CSM_OFS_PROD_LO: begin
        rdata = res_out.product[31:0];
      end
      CSM_OFS_PROD_HI: begin
        rdata[3:0] = res_out.product[35:32];
      end
      CSM_OFS_COUNT: begin
        rdata = regs_ff.count;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    nxt_regs = regs_ff;

    // one wait state: ready rises in the second access cycle
    nxt_regs.pready = acc_phase & ~regs_ff.pready;
    if (acc_phase && !regs_ff.pready) begin
      nxt_regs.prdata  = req.pwrite ? 32'h00000000 : rdata;
      nxt_regs.pslverr = ~hit;
    end else if (!acc_phase) begin
      nxt_regs.prdata  = CSM_RDATA_RST;
      nxt_regs.pslverr = 1'b0;
    end

    // count edges with CLK_EN high, whether or not ACLR holds the slice registers clear
    if (CLK_EN) begin
      nxt_regs.count = regs_ff.count + 32'h00000001;
    end

    // writes land only on the edge that completes the access
    if (acc_done && req.pwrite && hit) begin
      case (word_addr)
        CSM_OFS_CTRL: begin
          nxt_regs.cfg = csm_cfg_t'(req.pwdata[CSM_CTRL_W-1:0]);
        end
        CSM_OFS_COUNT: begin
          // a product in the same cycle still counts
          nxt_regs.count = CLK_EN ? 32'h00000001 : CSM_COUNT_RST;
        end
        default: begin
          nxt_regs.cfg = regs_ff.cfg;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      regs_ff.cfg     <= csm_cfg_t'(CSM_CTRL_RST);
      regs_ff.pready  <= 1'b0;
      regs_ff.pslverr <= 1'b0;
      regs_ff.prdata  <= CSM_RDATA_RST;
      regs_ff.count   <= CSM_COUNT_RST;
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  assign PRDATA  = regs_ff.prdata;
  assign PREADY  = regs_ff.pready;
  assign PSLVERR = regs_ff.pslverr;

endmodule : csm_top
`default_nettype wire

//--- test/csm_ref.svh
// reference product of the slice in wide and narrow form
// included inside each module that needs it, so each keeps its own copy
function automatic logic [35:0] csm_ref(input logic [17:0] a,
  input logic [17:0] b, input logic sa, input logic sb, input logic nw);
  logic signed [37:0] w;
  logic signed [19:0] l0;
  logic signed [19:0] l1;
  w  = $signed({sa & a[17], a}) * $signed({sb & b[17], b});
  l0 = $signed({sa & a[8], a[8:0]}) * $signed({sb & b[8], b[8:0]});
  l1 = $signed({sa & a[17], a[17:9]}) * $signed({sb & b[17], b[17:9]});
  return nw ? {l1[17:0], l0[17:0]} : w[35:0];
endfunction : csm_ref

//--- test/csm_sva.sv
// port assertions of the multiplier slice
`timescale 1ns/100ps
`default_nettype none
module csm_sva
  import csm_pkg::*;
(
  // clock, reset, apb
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // slice
  input wire logic        CLK_EN,
  input wire logic        ACLR,
  input wire logic [17:0] DATA_A,
  input wire logic [17:0] DATA_B,
  input wire logic        SIGN_A,
  input wire logic        SIGN_B,
  input wire logic [35:0] PRODUCT,
  input wire logic        RESULT_SIGNED
);
  `include "csm_ref.svh"
  csm_cfg_t    cfg_ff;
  logic [1:0]  ok_ff;
  logic [35:0] fexp;
  logic        comb;
  logic        full;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // shadow control word; ok_ff marks edges that really loaded the slice
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cfg_ff <= '0;
      ok_ff  <= 2'h0;
    end else begin
      if (PSEL && PENABLE && PREADY && PWRITE && PADDR[11:2] == 10'h000)
        cfg_ff <= csm_cfg_t'(PWDATA[5:0]);
      ok_ff <= {ok_ff[0], CLK_EN && !ACLR};
    end
  end
  assign fexp = csm_ref(DATA_A, DATA_B, SIGN_A & cfg_ff.sign_en,
                        SIGN_B & cfg_ff.sign_en, cfg_ff.narrow);
  assign comb = cfg_ff[4:1] == 4'h0;
  assign full = cfg_ff[4:1] == 4'hF;
  AST_COMB_PROD: assert property (comb |-> PRODUCT == fexp)
    else $error("combinational product wrong");
  AST_COMB_SIGN: assert property (comb |-> RESULT_SIGNED ==
    (cfg_ff.sign_en && (SIGN_A || SIGN_B))) else $error("sign flag wrong");
  AST_DEF_UNS: assert property (comb && !cfg_ff.sign_en |->
    !RESULT_SIGNED && PRODUCT == (cfg_ff.narrow ?
    {{9'h000, DATA_A[17:9]} * {9'h000, DATA_B[17:9]},
     {9'h000, DATA_A[8:0]} * {9'h000, DATA_B[8:0]}} :
    {18'h00000, DATA_A} * {18'h00000, DATA_B}))
    else $error("default not unsigned");
  AST_OUT_REG: assert property (cfg_ff[4:1] == 4'h8 && ok_ff[0] &&
    !ACLR && cfg_ff == $past(cfg_ff) |-> PRODUCT == $past(fexp))
    else $error("output register latency wrong");
  AST_PIPE: assert property (full && ok_ff == 2'h3 && !ACLR &&
    cfg_ff == $past(cfg_ff) && cfg_ff == $past(cfg_ff, 2)
    |-> PRODUCT == $past(fexp, 2)) else $error("pipeline product wrong");
  AST_HOLD: assert property (cfg_ff.reg_out && !$past(CLK_EN) &&
    !ACLR && !$past(ACLR) && cfg_ff == $past(cfg_ff) |-> $stable(PRODUCT))
    else $error("product moved with enable low");
  AST_CLEAR: assert property (cfg_ff.reg_out && ACLR |->
    PRODUCT == 36'h0) else $error("clear left product");
  AST_READY: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
    else $error("ready not after one wait state");
  AST_ERR: assert property (PREADY |-> PSLVERR == (PADDR[11:2] > 10'h004))
    else $error("slave error flag wrong");
  cover property (comb && cfg_ff.narrow && cfg_ff.sign_en);
  cover property (full && ok_ff == 2'h3);
  cover property (cfg_ff.reg_out && ACLR);
endmodule : csm_sva
bind csm_top csm_sva sva_u (.CLK(CLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .CLK_EN(CLK_EN), .ACLR(ACLR),
  .DATA_A(DATA_A), .DATA_B(DATA_B), .SIGN_A(SIGN_A), .SIGN_B(SIGN_B),
  .PRODUCT(PRODUCT), .RESULT_SIGNED(RESULT_SIGNED));
`default_nettype wire

//--- test/csm_fabric.sv
// fabric logic that feeds operands and slice controls
`timescale 1ns/100ps
`default_nettype none
module csm_fabric (
  // clock
  input  wire logic        CLK,
  // to the slice
  output var  logic [17:0] DATA_A,
  output var  logic [17:0] DATA_B,
  output var  logic        SIGN_A,
  output var  logic        SIGN_B,
  output var  logic        CLK_EN,
  output var  logic        ACLR
);
  initial begin
    DATA_A = 18'h00000;
    DATA_B = 18'h00000;
    SIGN_A = 1'b0;
    SIGN_B = 1'b0;
    CLK_EN = 1'b0;
    ACLR   = 1'b0;
  end
  // one sign per operand serves both narrow lanes alike
  task automatic put(input logic [17:0] a, input logic [17:0] b,
    input logic sa, input logic sb, input logic en, input logic clr);
    @(posedge CLK);
    DATA_A <= a;
    DATA_B <= b;
    SIGN_A <= sa;
    SIGN_B <= sb;
    CLK_EN <= en;
    ACLR   <= clr;
  endtask : put
endmodule : csm_fabric
`default_nettype wire

//--- test/csm_tb_top.sv
// self-checking bench of the multiplier slice
`timescale 1ns/100ps
`default_nettype none
module csm_tb_top;
  import csm_pkg::*;
  `include "csm_ref.svh"
  logic        CLK;
  logic        RST;
  logic        PSEL;
  logic        PENABLE;
  logic        PWRITE;
  logic [11:0] PADDR;
  logic [31:0] PWDATA;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic [17:0] DATA_A;
  logic [17:0] DATA_B;
  logic        SIGN_A;
  logic        SIGN_B;
  logic        CLK_EN;
  logic        ACLR;
  logic [35:0] PRODUCT;
  logic        RESULT_SIGNED;
  logic [31:0] rdat;
  logic        rerr;
  logic [35:0] expv;
  int          fail_count;
  int          n_tests;
  csm_top dut_u (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .CLK_EN(CLK_EN), .ACLR(ACLR),
    .DATA_A(DATA_A), .DATA_B(DATA_B), .SIGN_A(SIGN_A), .SIGN_B(SIGN_B),
    .PRODUCT(PRODUCT), .RESULT_SIGNED(RESULT_SIGNED));
  csm_fabric fab_u (.CLK(CLK), .DATA_A(DATA_A), .DATA_B(DATA_B),
    .SIGN_A(SIGN_A), .SIGN_B(SIGN_B), .CLK_EN(CLK_EN), .ACLR(ACLR));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  // ready is sampled at the rising edge; the request holds through it
  task automatic xfer(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    int i;
    @(posedge CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    i = 0;
    do begin
      @(posedge CLK);
      i++;
    end while (PREADY !== 1'b1 && i < 16);
    if (i >= 16) chk(PREADY, 40'h1);
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : xfer
  task automatic close_out();
    if (fail_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (4000) @(posedge CLK);
    fail_count++;
    close_out();
  end
  initial begin
    RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h00000000;
    fail_count = 0;
    n_tests = 0;
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    xfer(1'b0, CSM_OFS_CTRL, 32'h0);
    chk(rdat, 40'h0);
    xfer(1'b1, 12'h020, 32'hFFFF);
    chk({rerr, rdat}, 40'h100000000);
    // sign inputs high must not matter until signs are enabled
    fab_u.put(18'h3FFFF, 18'h3FFFF, 1'b1, 1'b1, 1'b1, 1'b0);
    @(negedge CLK);
    chk({RESULT_SIGNED, PRODUCT}, {1'b0, 36'hFFFF80001});
    for (int m = 0; m < 8; m++) begin
      if (m % 4 == 0) xfer(1'b1, CSM_OFS_CTRL, {31'h10, m[2]});
      fab_u.put(18'h20003, 18'h3FE02, m[0], m[1], 1'b1, 1'b0);
      @(negedge CLK);
      expv = csm_ref(18'h20003, 18'h3FE02, m[0], m[1], m[2]);
      chk({RESULT_SIGNED, PRODUCT}, {m[0] | m[1], expv});
    end
    xfer(1'b0, CSM_OFS_PROD_LO, 32'h0);
    chk(rdat, expv[31:0]);
    xfer(1'b0, CSM_OFS_PROD_HI, 32'h0);
    chk(rdat, expv[35:32]);
    // narrow lanes, both signs in use, signed result
    xfer(1'b0, CSM_OFS_STATUS, 32'h0);
    chk(rdat, 40'hF);
    // output register alone, then every register in the path
    for (int k = 0; k < 2; k++) begin
      xfer(1'b1, CSM_OFS_CTRL, k ? 32'h3E : 32'h30);
      fab_u.put(18'h2ABCD, 18'h1F0F0, 1'b1, 1'b0, 1'b1, 1'b0);
      fab_u.put(18'h00005, 18'h3FFF9, 1'b0, 1'b1, 1'b1, 1'b0);
      repeat (k) @(posedge CLK);
      @(negedge CLK);
      expv = csm_ref(18'h2ABCD, 18'h1F0F0, 1'b1, 1'b0, 1'b0);
      chk({RESULT_SIGNED, PRODUCT}, {1'b1, expv});
      @(negedge CLK);
      expv = csm_ref(18'h00005, 18'h3FFF9, 1'b0, 1'b1, 1'b0);
      chk({RESULT_SIGNED, PRODUCT}, {1'b1, expv});
      fab_u.put(18'h3FFFF, 18'h3FFFF, 1'b1, 1'b1, 1'b0, 1'b0);
      repeat (3) @(negedge CLK);
      chk(PRODUCT, expv);
      fab_u.put(18'h3FFFF, 18'h3FFFF, 1'b1, 1'b1, 1'b0, 1'b1);
      @(negedge CLK);
      chk(PRODUCT, 40'h0);
      fab_u.put(18'h00000, 18'h00000, 1'b0, 1'b0, 1'b1, 1'b0);
    end
    // one operand registered, the other direct
    for (int j = 1; j < 3; j++) begin
      xfer(1'b1, CSM_OFS_CTRL, {26'h0, 1'b1, 2'h0, j[1:0], 1'b0});
      fab_u.put(18'h2ABCD, 18'h1F0F0, 1'b1, 1'b1, 1'b1, 1'b0);
      fab_u.put(18'h00005, 18'h3FFF9, 1'b1, 1'b1, 1'b1, 1'b0);
      @(negedge CLK);
      expv = csm_ref(j[0] ? 18'h2ABCD : 18'h00005,
                     j[1] ? 18'h1F0F0 : 18'h3FFF9, 1'b1, 1'b1, 1'b0);
      chk({RESULT_SIGNED, PRODUCT}, {1'b1, expv});
    end
    // counter cleared with the enable low, then three enabled edges
    fab_u.put(18'h00000, 18'h00000, 1'b0, 1'b0, 1'b0, 1'b0);
    xfer(1'b1, CSM_OFS_COUNT, 32'h0);
    xfer(1'b0, CSM_OFS_COUNT, 32'h0);
    chk(rdat, 40'h0);
    fab_u.put(18'h00000, 18'h00000, 1'b0, 1'b0, 1'b1, 1'b0);
    repeat (2) @(posedge CLK);
    fab_u.put(18'h00000, 18'h00000, 1'b0, 1'b0, 1'b0, 1'b0);
    xfer(1'b0, CSM_OFS_COUNT, 32'h0);
    chk(rdat, 40'h3);
    close_out();
  end
endmodule : csm_tb_top
`default_nettype wire
